// ===== test/core_fetch_model.sv
// Purpose: stand-in for the core's fetch sequencer at the restart handshake
// Assumes: stall sets how many cycles the core waits before taking the fetch
// Notes: fetch_taken is a one-cycle accept
`timescale 1ns/100ps
module core_fetch_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic fetch_valid,
    input wire logic [3:0] stall,
    output logic fetch_taken
);
    logic [3:0] wait_cnt;
    // the word at zero holds a jump, so the core only ever takes the fetch at that address
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wait_cnt <= 4'h0;
            fetch_taken <= 1'b0;
        end else if (fetch_valid && !fetch_taken) begin
            fetch_taken <= (wait_cnt == stall);
            wait_cnt <= wait_cnt + 4'h1;
        end else begin
            fetch_taken <= 1'b0;
            wait_cnt <= 4'h0;
        end
    end
endmodule // core_fetch_model

// ===== test/reset_and_vector_table_map_tb_top.sv
// Purpose: self-checking bench for restart and vector address generation
// Assumes: irq 4 is left unimplemented to exercise masking
// Notes: expectations come from exp_num and the table bases
`timescale 1ns/100ps
module reset_and_vector_table_map_tb_top;
    // unused slots point at a resetting handler, so irq 4 must never be dispatched
    localparam logic [117:0] IMPL = ~(118'h1 << 4);
    logic core_clk, rst, alt_table_select, dispatch_req, fetch_taken, fetch_valid, core_running, vec_valid;
    logic [3:0] trap_req, stall;
    logic [117:0] irq_req;
    logic [6:0] vec_num;
    vector_map_pkg::prog_addr_t fetch_addr, pc_out, vec_addr;
    int error_cnt, check_count;
    reset_and_vector_table_map #(.IRQ_IMPL(IMPL)) i_reset_and_vector_table_map (.core_clk(core_clk), .rst(rst),
        .alt_table_select(alt_table_select), .trap_req(trap_req), .irq_req(irq_req), .dispatch_req(dispatch_req),
        .fetch_taken(fetch_taken), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .pc_out(pc_out),
        .core_running(core_running), .vec_valid(vec_valid), .vec_num(vec_num), .vec_addr(vec_addr));
    core_fetch_model i_core_fetch_model (.core_clk(core_clk), .rst(rst), .fetch_valid(fetch_valid),
        .stall(stall), .fetch_taken(fetch_taken));
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task automatic test_done;
        if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [6:0] exp_num(input logic [3:0] t, input logic [117:0] q, output logic hit);
        exp_num = 7'h00;
        hit = 1'b0;
        for (int i = 117; i >= 0; i--) if (q[i] && IMPL[i]) begin hit = 1'b1; exp_num = 7'(i + 8); end
        for (int i = 3; i >= 0; i--) if (t[i]) begin hit = 1'b1; exp_num = 7'(i + 1); end
    endfunction
    task automatic disp(input logic [3:0] t, input logic [117:0] q, input logic a);
        logic hit;
        logic [6:0] n;
        vector_map_pkg::prog_addr_t ea;
        n = exp_num(t, q, hit);
        ea = (a ? vector_map_pkg::ALT_BASE : vector_map_pkg::PRIMARY_BASE) + {16'h0, n, 1'b0};
        @(posedge core_clk);
        trap_req <= t;
        irq_req <= q;
        alt_table_select <= a;
        dispatch_req <= 1'b1;
        @(posedge core_clk);
        dispatch_req <= 1'b0;
        #1;
        chk(vec_valid === hit, "vector pulse wrong");
        if (hit) chk(vec_num === n, "vector number wrong");
        if (hit) chk(vec_addr === ea, "vector address wrong");
    endtask
    task automatic restart(input logic [3:0] s);
        stall <= s;
        rst <= 1'b1;
        dispatch_req <= 1'b1;
        irq_req <= 118'h1;
        repeat (5) @(posedge core_clk);
        #1 chk(!fetch_valid && pc_out === 24'h0 && !core_running && !vec_valid, "reset state");
        @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1 chk(fetch_valid && fetch_addr === vector_map_pkg::RESET_ADDR && pc_out === 24'h0, "first fetch");
        for (int i = 0; i < 20 && !core_running; i++) begin
            @(posedge core_clk);
            #1 chk(vec_valid === 1'b0, "dispatch during restart");
        end
        chk(core_running && !fetch_valid && pc_out === vector_map_pkg::GOTO_TARGET_ADDR, "restart");
        @(posedge core_clk);
        dispatch_req <= 1'b0;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        #500000;
        error_cnt++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        {alt_table_select, dispatch_req, trap_req, irq_req, stall} = '0;
        error_cnt = 0;
        check_count = 0;
        void'($urandom(32'h0955));
        restart(4'h0);
        disp(4'h0, 118'h1, 1'b0);
        chk(vec_addr === vector_map_pkg::PRI_IRQ_FIRST, "primary irq 0");
        disp(4'h0, 118'h1 << 117, 1'b1);
        chk(vec_addr === vector_map_pkg::ALT_IRQ_LAST, "alternate irq 117");
        disp(4'h0, 118'h10, 1'b0);
        disp(4'hf, ~118'h0, 1'b1);
        disp(4'h8, 118'h1, 1'b0);
        disp(4'h0, 118'h0, 1'b0);
        repeat (300) disp(($urandom % 4 == 0) ? 4'($urandom) : 4'h0,
            (118'h1 << ($urandom % 118)) | (118'h1 << ($urandom % 118)), 1'($urandom));
        restart(4'h6);
        repeat (20) disp(4'($urandom), 118'h1 << ($urandom % 118), 1'($urandom));
        test_done();
    end
endmodule // reset_and_vector_table_map_tb_top

// ===== verilog/reset_and_vector_table_map.sv
// Purpose: restart sequencing and vector fetch address generation for the core
// Assumes: requests and select come from logic on core_clk; rst merges all reset sources
// Notes: fetch_valid holds until fetch_taken; a dispatch answer is a one-cycle pulse
`timescale 1ns/100ps
module reset_and_vector_table_map #(
    parameter logic [vector_map_pkg::NUM_IRQ-1:0] IRQ_IMPL = {vector_map_pkg::NUM_IRQ{1'b1}}
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic alt_table_select,
    input wire logic [3:0] trap_req,
    input wire logic [vector_map_pkg::NUM_IRQ-1:0] irq_req,
    input wire logic dispatch_req,
    input wire logic fetch_taken,
    output logic fetch_valid,
    output vector_map_pkg::prog_addr_t fetch_addr,
    output vector_map_pkg::prog_addr_t pc_out,
    output logic core_running,
    output logic vec_valid,
    output logic [vector_map_pkg::VNUM_W-1:0] vec_num,
    output vector_map_pkg::prog_addr_t vec_addr
);
    typedef enum logic [1:0] {
        ST_FIRST_FETCH,
        ST_RUN
    } seq_e;

    typedef struct packed {
        seq_e state;
        vector_map_pkg::prog_addr_t pc;
        logic fetch_valid;
        logic running;
        vector_map_pkg::vec_out_s vec;
    } state_s;

    localparam logic [vector_map_pkg::NUM_VEC-1:0] VEC_IMPL = {IRQ_IMPL, vector_map_pkg::TRAP_IMPL};

    function automatic vector_map_pkg::prog_addr_t vec_fetch_addr(input logic alt,
                                                                  input logic [vector_map_pkg::VNUM_W-1:0] num);
        vector_map_pkg::prog_addr_t base;
        base = alt ? vector_map_pkg::ALT_BASE : vector_map_pkg::PRIMARY_BASE;
        return base + {16'h0000, num, 1'b0};
    endfunction

    function automatic logic [vector_map_pkg::NUM_VEC-1:0] below_mask(input logic [vector_map_pkg::VNUM_W-1:0] num);
        logic [vector_map_pkg::NUM_VEC-1:0] m;
        m = '0;
        for (int i = 0; i < vector_map_pkg::NUM_VEC; i++) begin
            m[i] = (i < int'(num));
        end
        return m;
    endfunction

    state_s cur_reg;
    state_s cur_next;
    logic [vector_map_pkg::NUM_VEC-1:0] pending;
    logic pick_found;
    logic [vector_map_pkg::VNUM_W-1:0] pick_index;

    // trap slots 1..4 carry the four trap requests; unimplemented slots never reach the picker
    assign pending = {irq_req, 3'b000, trap_req, 1'b0} & VEC_IMPL;

    vector_priority_pick #(
        .N(vector_map_pkg::NUM_VEC)
    ) u_pick (
        .pending(pending),
        .found(pick_found),
        .index(pick_index)
    );

    always_comb begin
        cur_next = cur_reg;
        cur_next.vec.valid = 1'b0;
        case (cur_reg.state)
            ST_FIRST_FETCH: begin
                // no vector dispatch here: restart runs apart from interrupt handling
                cur_next.fetch_valid = 1'b1;
                if (cur_reg.fetch_valid && fetch_taken) begin
                    cur_next.fetch_valid = 1'b0;
                    cur_next.pc = vector_map_pkg::GOTO_TARGET_ADDR;
                    cur_next.running = 1'b1;
                    cur_next.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (dispatch_req && pick_found) begin
                    cur_next.vec.valid = 1'b1;
                    cur_next.vec.num = pick_index;
                    cur_next.vec.addr = vec_fetch_addr(alt_table_select, pick_index);
                end
            end
            default: begin
                cur_next.running = 1'b0;
                cur_next.state = ST_FIRST_FETCH;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // everything cleared; pc held at the reset location
            cur_reg.state <= ST_FIRST_FETCH;
            cur_reg.pc <= vector_map_pkg::RESET_ADDR;
            cur_reg.fetch_valid <= 1'b0;
            cur_reg.running <= 1'b0;
            cur_reg.vec.valid <= 1'b0;
            cur_reg.vec.num <= '0;
            cur_reg.vec.addr <= vector_map_pkg::RESET_ADDR;
        end else begin
            cur_reg <= cur_next;
        end
    end

    always_comb begin
        fetch_valid = cur_reg.fetch_valid;
        fetch_addr = cur_reg.pc;
        pc_out = cur_reg.pc;
        core_running = cur_reg.running;
        vec_valid = cur_reg.vec.valid;
        vec_num = cur_reg.vec.num;
        vec_addr = cur_reg.vec.addr;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // restart handshake
    first_fetch_zero_a: assert property (
        fetch_valid |-> fetch_addr == vector_map_pkg::RESET_ADDR)
        else $error("first fetch not at reset address");

    fetch_follows_release_a: assert property (
        $rose(fetch_valid) |-> pc_out == vector_map_pkg::RESET_ADDR && !core_running)
        else $error("pc not cleared at first fetch");

    fetch_holds_a: assert property (
        fetch_valid && !fetch_taken |=> fetch_valid)
        else $error("reset fetch dropped before it was taken");

    fetch_take_a: assert property (
        fetch_valid && fetch_taken |=> !fetch_valid && core_running && pc_out == vector_map_pkg::GOTO_TARGET_ADDR)
        else $error("reset fetch take did not start the core");

    restart_pc_zero_a: assert property (
        !core_running |-> pc_out == vector_map_pkg::RESET_ADDR)
        else $error("pc not zero during restart");

    running_holds_a: assert property (
        core_running |=> core_running)
        else $error("core stopped without a reset");

    no_vec_in_restart_a: assert property (
        !core_running |-> !vec_valid)
        else $error("vector dispatched during restart");

    // vector address generation
    vec_addr_calc_a: assert property (
        vec_valid |-> vec_addr == vec_fetch_addr($past(alt_table_select), vec_num))
        else $error("vector address not base plus twice number");

    trap_area_a: assert property (
        vec_valid && vec_num < vector_map_pkg::IRQ_VEC0 |->
        vec_num >= vector_map_pkg::TRAP_OSC_FAIL && vec_num <= vector_map_pkg::TRAP_MATH)
        else $error("reserved trap slot dispatched");

    trap_base_a: assert property (
        vec_valid && !$past(alt_table_select) && vec_num < vector_map_pkg::IRQ_VEC0 |->
        vec_addr > vector_map_pkg::PRIMARY_BASE && vec_addr < vector_map_pkg::PRI_IRQ_FIRST)
        else $error("trap vector outside the primary trap area");

    primary_irq_range_a: assert property (
        vec_valid && !$past(alt_table_select) && vec_num >= vector_map_pkg::IRQ_VEC0 |->
        vec_addr >= vector_map_pkg::PRI_IRQ_FIRST && vec_addr <= vector_map_pkg::PRI_IRQ_LAST)
        else $error("primary interrupt vector out of range");

    primary_rsvd_a: assert property (
        vec_valid |-> vec_addr != vector_map_pkg::PRI_RSVD_A && vec_addr != vector_map_pkg::PRI_RSVD_B)
        else $error("reserved word used as a vector");

    alt_irq_range_a: assert property (
        vec_valid && $past(alt_table_select) && vec_num >= vector_map_pkg::IRQ_VEC0 |->
        vec_addr >= vector_map_pkg::ALT_IRQ_FIRST && vec_addr <= vector_map_pkg::ALT_IRQ_LAST)
        else $error("alternate interrupt vector out of range");

    below_user_code_a: assert property (
        vec_valid |-> vec_addr < vector_map_pkg::USER_CODE_ADDR)
        else $error("vector address inside user code");

    vec_addr_even_a: assert property (
        vec_valid |-> !vec_addr[0])
        else $error("vector entry not word aligned");

    alt_select_a: assert property (
        vec_valid |-> (vec_addr >= vector_map_pkg::ALT_BASE) == $past(alt_table_select))
        else $error("vector fetched from wrong table");

    // dispatch choice
    natural_priority_a: assert property (
        vec_valid |-> ($past(pending) & below_mask(vec_num)) == '0)
        else $error("lower vector was pending but skipped");

    implemented_only_a: assert property (
        vec_valid |-> (($past(pending) >> vec_num) & {{(vector_map_pkg::NUM_VEC-1){1'b0}}, 1'b1}) != '0 &&
        VEC_IMPL[vec_num])
        else $error("unimplemented or idle vector dispatched");

    idle_no_answer_a: assert property (
        !(core_running && dispatch_req && pick_found) |=> !vec_valid)
        else $error("vector answer without a pending request");

    dispatch_answer_a: assert property (
        core_running && dispatch_req && pick_found |=> vec_valid)
        else $error("dispatch request not answered next cycle");
endmodule // reset_and_vector_table_map

// ===== verilog/vector_map_pkg.sv
// Purpose: shared constants and carriers for the reset and vector map block
// Assumes: word addresses step by two, as in program memory
// Notes: trap entries occupy vector numbers 0 to 7, interrupts 8 to 125
package vector_map_pkg;
    localparam int ADDR_W = 24;
    localparam int NUM_TRAP = 8;
    localparam int NUM_IRQ = 118;
    localparam int NUM_VEC = NUM_TRAP + NUM_IRQ;
    localparam int VNUM_W = 7;

    typedef logic [ADDR_W-1:0] prog_addr_t;

    localparam prog_addr_t RESET_ADDR = 24'h000000;
    localparam prog_addr_t GOTO_TARGET_ADDR = 24'h000002;
    localparam prog_addr_t PRIMARY_BASE = 24'h000004;
    localparam prog_addr_t ALT_BASE = 24'h000104;
    localparam prog_addr_t PRI_IRQ_FIRST = 24'h000014;
    localparam prog_addr_t PRI_IRQ_LAST = 24'h0000fe;
    localparam prog_addr_t PRI_RSVD_A = 24'h000100;
    localparam prog_addr_t PRI_RSVD_B = 24'h000102;
    localparam prog_addr_t ALT_IRQ_FIRST = 24'h000114;
    localparam prog_addr_t ALT_IRQ_LAST = 24'h0001fe;
    localparam prog_addr_t USER_CODE_ADDR = 24'h000200;

    // trap slots: 0 reserved, 1 osc fail, 2 address, 3 stack, 4 math, 5..7 reserved
    localparam logic [VNUM_W-1:0] TRAP_OSC_FAIL = 7'h01;
    localparam logic [VNUM_W-1:0] TRAP_MATH = 7'h04;
    localparam logic [VNUM_W-1:0] IRQ_VEC0 = 7'h08;
    localparam logic [NUM_TRAP-1:0] TRAP_IMPL = 8'h1e;

    typedef struct packed {
        logic valid;
        logic [VNUM_W-1:0] num;
        prog_addr_t addr;
    } vec_out_s;
endpackage

// ===== verilog/vector_priority_pick.sv
// Purpose: picks the lowest-numbered pending vector
// Assumes: pending is already masked with the implemented set
// Notes: purely combinational
`timescale 1ns/100ps
module vector_priority_pick #(
    parameter int N = vector_map_pkg::NUM_VEC
) (
    input wire logic [N-1:0] pending,
    output logic found,
    output logic [vector_map_pkg::VNUM_W-1:0] index
);
    always_comb begin
        found = 1'b0;
        index = '0;
        // scan downward so the lowest set position is the one left standing
        for (int i = N - 1; i >= 0; i--) begin
            if (pending[i]) begin
                found = 1'b1;
                index = vector_map_pkg::VNUM_W'(i);
            end
        end
    end
endmodule // vector_priority_pick
